// File: verilog/amplitude_threshold_detect.sv
// Two-channel amplitude threshold detector with APB register file and interrupt
`timescale 1ns/1ps
module amplitude_threshold_detect
    import amplitude_threshold_detect_pkg::*;
(
    input  wire logic                          clock,               // 125 MHz sample clock
    input  wire logic                          arst_n,              // Async reset, active low
    input  wire logic [ADDR_W-1:0]             paddr,               // APB address
    input  wire logic                          psel,                // APB select
    input  wire logic                          penable,             // APB enable
    input  wire logic                          pwrite,              // APB write
    input  wire logic [DATA_W-1:0]             pwdata,              // APB write data
    input  wire logic [3:0]                    pstrb,               // APB byte strobes
    output logic [DATA_W-1:0]                  prdata,              // APB read data
    output logic                               pready,              // APB ready
    output logic                               pslverr,             // APB error
    input  wire logic [NUM_CH-1:0][THR_W-1:0]  sampleMag,           // Fine magnitude per channel
    input  wire logic [NUM_CH-1:0]             sampleValid,         // Magnitude valid per channel
    output logic                               level_alarm_out_ch1, // Detect pin, channel 1
    output logic                               level_alarm_out_ch2, // Detect pin, channel 2
    output logic                               irq                  // Level interrupt, active high
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic                  setupPhase;
    logic                  accessPhase;
    logic [9:0]            regIdx;
    logic                  chSel;
    logic                  addrOk;
    logic                  isGlobal;
    logic                  isLocal;
    logic                  wrLane0;
    logic [7:0]            wrByte;

    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    assign regIdx      = paddr[IDX_MSB:IDX_LSB];
    assign chSel       = paddr[CH_SEL_BIT];
    assign addrOk      = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:CH_SEL_BIT+1] == '0);
    assign isGlobal    = addrOk && !chSel && ((regIdx == IDX_IRQ_STATUS) || (regIdx == IDX_IRQ_MASK));
    assign isLocal     = addrOk && ((regIdx == IDX_CTRL)  || (regIdx == IDX_UP_LO) ||
                                    (regIdx == IDX_UP_HI) || (regIdx == IDX_LO_LO) ||
                                    (regIdx == IDX_LO_HI) || (regIdx == IDX_DW_LO) ||
                                    (regIdx == IDX_DW_HI));
    assign wrLane0     = pstrb[0];
    assign wrByte      = pwdata[7:0];

    // ------------------------------------------------------------------
    // Setup-phase capture: read data and error are ready for access
    // ------------------------------------------------------------------
    chanRegs_t              regs_q [NUM_CH];
    logic [IRQ_W-1:0]       status_q;
    logic [IRQ_W-1:0]       mask_q;
    logic [IRQ_W-1:0]       evtSet;
    logic [IRQ_W-1:0]       rdClear_q;
    logic [DATA_W-1:0]      prdata_q;
    logic                   pslverr_q;
    logic [7:0]             rdByte;
    logic                   rdIsStatus;
    chanRegs_t              selRegs;

    assign selRegs    = regs_q[chSel];
    assign rdIsStatus = isGlobal && (regIdx == IDX_IRQ_STATUS);

    always_comb begin
        rdByte = 8'h00;
        if (isGlobal) begin
            if (regIdx == IDX_IRQ_STATUS) begin
                rdByte = {{(8-IRQ_W){1'b0}}, status_q};
            end else begin
                rdByte = {{(8-IRQ_W){1'b0}}, mask_q};
            end
        end else if (isLocal) begin
            case (regIdx)
                IDX_CTRL:  rdByte = selRegs.ctrl & CTRL_WR_MASK;
                IDX_UP_LO: rdByte = selRegs.upLo;
                IDX_UP_HI: rdByte = selRegs.upHi & HI_THR_MASK;
                IDX_LO_LO: rdByte = selRegs.loLo;
                IDX_LO_HI: rdByte = selRegs.loHi & HI_THR_MASK;
                IDX_DW_LO: rdByte = selRegs.dwLo;
                IDX_DW_HI: rdByte = selRegs.dwHi;
                default:   rdByte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            rdClear_q <= IRQ_RESET;
        end else if (setupPhase) begin
            prdata_q  <= {24'h00_0000, rdByte};
            pslverr_q <= !(isGlobal || isLocal);
            rdClear_q <= (!pwrite && rdIsStatus) ? status_q : IRQ_RESET;
        end
    end

    // Zero wait states: the access phase always completes at once
    assign pready  = accessPhase;
    assign prdata  = prdata_q;
    assign pslverr = accessPhase && pslverr_q;

    // ------------------------------------------------------------------
    // Channel register file
    // ------------------------------------------------------------------
    logic wrStrobe;

    assign wrStrobe = accessPhase && pwrite && !pslverr_q && wrLane0;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_regs
        logic wrCh;

        assign wrCh = wrStrobe && isLocal && (chSel == 1'(ch));

        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                regs_q[ch] <= {7{REG_RESET}};
            end else if (wrCh) begin
                case (regIdx)
                    IDX_CTRL:  regs_q[ch].ctrl <= wrByte & CTRL_WR_MASK;
                    IDX_UP_LO: regs_q[ch].upLo <= wrByte;
                    IDX_UP_HI: regs_q[ch].upHi <= wrByte & HI_THR_MASK;
                    IDX_LO_LO: regs_q[ch].loLo <= wrByte;
                    IDX_LO_HI: regs_q[ch].loHi <= wrByte & HI_THR_MASK;
                    IDX_DW_LO: regs_q[ch].dwLo <= wrByte;
                    IDX_DW_HI: regs_q[ch].dwHi <= wrByte;
                    default:   regs_q[ch]      <= regs_q[ch];
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    logic wrMask;
    logic rdDone;

    assign wrMask = wrStrobe && isGlobal && (regIdx == IDX_IRQ_MASK);
    assign rdDone = accessPhase && !pwrite;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= IRQ_RESET;
        end else if (wrMask) begin
            mask_q <= wrByte[IRQ_W-1:0];
        end
    end

    // Only bits seen by the read are cleared; a new event wins
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= IRQ_RESET;
        end else if (rdDone) begin
            status_q <= (status_q & ~rdClear_q) | evtSet;
        end else begin
            status_q <= status_q | evtSet;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Detection channels
    // ------------------------------------------------------------------
    chanEvt_t [NUM_CH-1:0] evt;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
        chanCfg_t cfg;

        assign cfg.enable   = regs_q[ch].ctrl[CTRL_EN_BIT];
        assign cfg.forceOn  = regs_q[ch].ctrl[CTRL_FORCE_BIT];
        assign cfg.forceVal = regs_q[ch].ctrl[CTRL_FVAL_BIT];
        assign cfg.upper    = {regs_q[ch].upHi[THR_W-9:0], regs_q[ch].upLo};
        assign cfg.lower    = {regs_q[ch].loHi[THR_W-9:0], regs_q[ch].loLo};
        assign cfg.dwell    = {regs_q[ch].dwHi, regs_q[ch].dwLo};

        detect_channel u_chan (
            .clock       (clock),
            .arst_n      (arst_n),
            .cfg         (cfg),
            .magnitude   (sampleMag[ch]),
            .sampleValid (sampleValid[ch]),
            .evt         (evt[ch])
        );

        assign evtSet[2*ch+IRQ_RISE_OFS] = evt[ch].rise;
        assign evtSet[2*ch+IRQ_FALL_OFS] = evt[ch].fall;
    end

    assign level_alarm_out_ch1 = evt[0].alarm;
    assign level_alarm_out_ch2 = evt[1].alarm;

endmodule

// File: verilog/amplitude_threshold_detect_pkg.sv
// Constants, register map and carrier types of the amplitude threshold detector
package amplitude_threshold_detect_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 32;
    localparam int THR_W   = 13;
    localparam int DWELL_W = 16;
    localparam int NUM_CH  = 2;
    localparam int IRQ_W   = 2 * NUM_CH;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_CTRL       = 10'h245;
    localparam logic [9:0] IDX_UP_LO      = 10'h247;
    localparam logic [9:0] IDX_UP_HI      = 10'h248;
    localparam logic [9:0] IDX_LO_LO      = 10'h249;
    localparam logic [9:0] IDX_LO_HI      = 10'h24A;
    localparam logic [9:0] IDX_DW_LO      = 10'h24B;
    localparam logic [9:0] IDX_DW_HI      = 10'h24C;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h300;
    localparam logic [9:0] IDX_IRQ_MASK   = 10'h301;

    // Channel window select and address layout
    localparam int CH_SEL_BIT  = 12;
    localparam int IDX_LSB     = 2;
    localparam int IDX_MSB     = 11;

    // ------------------------------------------------------------------
    // Field positions, masks and reset values
    // ------------------------------------------------------------------
    localparam int         CTRL_FORCE_BIT = 3;
    localparam int         CTRL_FVAL_BIT  = 2;
    localparam int         CTRL_EN_BIT    = 0;
    localparam logic [7:0] CTRL_WR_MASK   = 8'h0D;
    localparam logic [7:0] HI_THR_MASK    = 8'h1F;
    localparam logic [7:0] FULL_MASK      = 8'hFF;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    // Event bit of channel n: rise at 2n, fall at 2n+1
    localparam int IRQ_RISE_OFS = 0;
    localparam int IRQ_FALL_OFS = 1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] upLo;
        logic [7:0] upHi;
        logic [7:0] loLo;
        logic [7:0] loHi;
        logic [7:0] dwLo;
        logic [7:0] dwHi;
    } chanRegs_t;

    typedef struct packed {
        logic               enable;
        logic               forceOn;
        logic               forceVal;
        logic [THR_W-1:0]   upper;
        logic [THR_W-1:0]   lower;
        logic [DWELL_W-1:0] dwell;
    } chanCfg_t;

    typedef struct packed {
        logic alarm;
        logic rise;
        logic fall;
    } chanEvt_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ALARM = 2'b01,
        ST_DWELL = 2'b10
    } detState_t;

endpackage

// File: verilog/dwell_timer.sv
// Counter of consecutive below-threshold samples against a dwell target
`timescale 1ns/1ps
module dwell_timer
    import amplitude_threshold_detect_pkg::*;
#(
    parameter int WIDTH = DWELL_W
) (
    input  wire logic             clock,   // Sample clock
    input  wire logic             arst_n,  // Async reset, active low
    input  wire logic             clear,   // Restart the count
    input  wire logic             step,    // Count one more sample
    input  wire logic [WIDTH-1:0] target,  // Dwell target value, compared with the count
    output logic                  hit      // This sample completes the dwell
);

    logic [WIDTH-1:0] count_q;

    // A target of zero behaves as one sample
    assign hit = ({1'b0, count_q} + {{WIDTH{1'b0}}, 1'b1}) >= {1'b0, target};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else if (clear) begin
            count_q <= '0;
        end else if (step && (count_q != {WIDTH{1'b1}})) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

// File: verilog/detect_channel.sv
// One channel of threshold detection with dwell release and pin override
`timescale 1ns/1ps
module detect_channel
    import amplitude_threshold_detect_pkg::*;
(
    input  wire logic             clock,       // Sample clock
    input  wire logic             arst_n,      // Async reset, active low
    input  wire chanCfg_t         cfg,         // Channel configuration
    input  wire logic [THR_W-1:0] magnitude,   // Fine sample magnitude
    input  wire logic             sampleValid, // Magnitude valid this cycle
    output chanEvt_t              evt          // Pin level and event pulses
);

    detState_t state_q;
    detState_t state_d;
    logic      active;
    logic      above;
    logic      below;
    logic      hit;
    logic      rise_d;
    logic      fall_d;
    logic      pin_q;
    logic      rise_q;
    logic      fall_q;

    assign active = cfg.enable && !cfg.forceOn;
    assign above  = sampleValid && (magnitude > cfg.upper);
    assign below  = sampleValid && (magnitude < cfg.lower);

    dwell_timer #(
        .WIDTH (DWELL_W)
    ) u_dwell (
        .clock  (clock),
        .arst_n (arst_n),
        .clear  (!active || (state_q == ST_IDLE) || (sampleValid && !below)),
        .step   (below),
        .target (cfg.dwell),
        .hit    (hit)
    );

    always_comb begin
        state_d = state_q;
        rise_d  = 1'b0;
        fall_d  = 1'b0;
        if (!active) begin
            state_d = ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (above) begin
                        state_d = ST_ALARM;
                        rise_d  = 1'b1;
                    end
                end
                ST_ALARM, ST_DWELL: begin
                    if (below && hit) begin
                        state_d = ST_IDLE;
                        fall_d  = 1'b1;
                    end else if (below) begin
                        state_d = ST_DWELL;
                    end else if (sampleValid) begin
                        state_d = ST_ALARM;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pin_q  <= 1'b0;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            pin_q  <= cfg.forceOn ? cfg.forceVal : (state_d != ST_IDLE);
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    assign evt.alarm = pin_q;
    assign evt.rise  = rise_q;
    assign evt.fall  = fall_q;

endmodule

// File: sim/agc_model.sv
// Gain control model on the far side of the detect pins
`timescale 1ns/1ps
module agc_model (
    input  wire logic            clock,     // Sample clock
    input  wire logic            arst_n,    // Async reset, active low
    input  wire logic [1:0]      alarm,     // Detect pins, index 0 = channel 1
    output logic [1:0][7:0]      stepCount  // Gain steps taken per channel
);
    logic [1:0] alarm_q;

    // ------------------------------------------------------------
    // One gain step on each rising pin
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            alarm_q   <= 2'b00;
            stepCount <= '0;
        end else begin
            alarm_q <= alarm;
            for (int c = 0; c < 2; c++) begin
                if (alarm[c] && !alarm_q[c]) begin
                    stepCount[c] <= stepCount[c] + 8'h01;
                end
            end
        end
    end
endmodule

// File: sim/amplitude_threshold_detect_checker.sv
// Concurrent checks on channel 1 and the APB bus of the threshold detector
`timescale 1ns/1ps
module detect_checker
    import amplitude_threshold_detect_pkg::*;
(
    input  wire logic                         clock,               // Sample clock
    input  wire logic                         arst_n,              // Async reset
    input  wire logic [ADDR_W-1:0]            paddr,               // APB address
    input  wire logic                         psel,                // APB select
    input  wire logic                         penable,             // APB enable
    input  wire logic                         pwrite,              // APB write
    input  wire logic [DATA_W-1:0]            pwdata,              // APB write data
    input  wire logic [3:0]                   pstrb,               // APB strobes
    input  wire logic                         pready,              // APB ready
    input  wire logic                         pslverr,             // APB error
    input  wire logic [NUM_CH-1:0][THR_W-1:0] sampleMag,           // Magnitudes
    input  wire logic [NUM_CH-1:0]            sampleValid,         // Valid strobes
    input  wire logic                         level_alarm_out_ch1, // Detect pin
    input  wire logic                         irq                  // Interrupt
);
    logic [7:0]       ctrl_q, upLo_q, upHi_q, loLo_q, loHi_q;
    logic [THR_W-1:0] upper, lower;
    logic             en, frc, fval, pin, hit, belowLo;

    // ------------------------------------------------------------
    // Shadow of the channel 1 settings
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {ctrl_q, upLo_q, upHi_q, loLo_q, loHi_q} <= '0;
        end else if (psel && penable && pwrite && pstrb[0]) begin
            case (paddr)
                16'h0914: ctrl_q <= pwdata[7:0] & CTRL_WR_MASK;
                16'h091c: upLo_q <= pwdata[7:0];
                16'h0920: upHi_q <= pwdata[7:0];
                16'h0924: loLo_q <= pwdata[7:0];
                16'h0928: loHi_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    assign upper = {upHi_q[4:0], upLo_q};
    assign lower = {loHi_q[4:0], loLo_q};
    assign en    = ctrl_q[CTRL_EN_BIT];
    assign frc   = ctrl_q[CTRL_FORCE_BIT];
    assign fval  = ctrl_q[CTRL_FVAL_BIT];
    assign pin   = level_alarm_out_ch1;
    assign hit   = sampleValid[0];
    assign belowLo = hit && (sampleMag[0] < lower);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_force_drives_pin: assert property (frc |=> pin == $past(fval))
        else $error("pin differs from override level");
    a_disabled_pin_low: assert property (!en && !frc |=> !pin)
        else $error("pin high while detection disabled");
    a_tie_no_rise: assert property (en && !frc && !pin && hit && sampleMag[0] <= upper |=> !pin)
        else $error("pin rose without exceeding upper threshold");
    // A pin left high by a just-released override is not a detection
    a_hold_at_lower: assert property (en && !frc && !$past(frc) && pin && (!hit || sampleMag[0] >= lower) |=> pin)
        else $error("pin released on sample not below lower threshold");
    a_fall_has_cause: assert property ($fell(pin) |-> !$past(en) || $past(frc) || $past(belowLo) || $past(frc, 2))
        else $error("pin fell without a below-threshold sample");
    a_rise_above_upper: assert property (en && !frc && hit && sampleMag[0] > upper |=> pin)
        else $error("pin did not rise above upper threshold");
    a_err_unaligned: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("no error on unaligned access");
    a_ready_in_access: assert property (psel && penable |-> pready)
        else $error("ready missing in access phase");

    c_pin_rise: cover property ($rose(pin));
    c_pin_fall: cover property ($fell(pin));
    c_irq_rise: cover property ($rose(irq));
endmodule

bind amplitude_threshold_detect detect_checker chk (.clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .sampleMag(sampleMag), .sampleValid(sampleValid), .level_alarm_out_ch1(level_alarm_out_ch1), .irq(irq));

// File: sim/testbench.sv
// Self-checking bench for the amplitude threshold detector
`timescale 1ns/1ps
module testbench;
    import amplitude_threshold_detect_pkg::*;
    logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic level_alarm_out_ch1, level_alarm_out_ch2;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = '0;
    logic [NUM_CH-1:0][THR_W-1:0] sampleMag = '0;
    logic [NUM_CH-1:0] sampleValid = '0;
    logic [1:0][7:0] stepCount;
    logic [12:0] up, lo;
    logic [7:0] d, steps0;
    int mismatches = 0, checks = 0, cycles = 0;
    const logic [15:0] offs[5] = '{16'h0914, 16'h091c, 16'h0920, 16'h0924, 16'h0928};

    amplitude_threshold_detect uut (.clock(clock), .arst_n(arst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleMag(sampleMag), .sampleValid(sampleValid),
        .level_alarm_out_ch1(level_alarm_out_ch1), .level_alarm_out_ch2(level_alarm_out_ch2), .irq(irq));
    agc_model partner (.clock(clock), .arst_n(arst_n), .alarm({level_alarm_out_ch2, level_alarm_out_ch1}),
        .stepCount(stepCount));

    always #4 clock = ~clock;

    // ------------------------------------------------------------
    // Shared tasks and expectations
    // ------------------------------------------------------------
    function automatic logic [31:0] readback(input logic [15:0] a, input logic [7:0] v);
        case (a[11:0])
            12'h914: return 32'(v & CTRL_WR_MASK);
            12'h920, 12'h928: return 32'(v & HI_THR_MASK);
            default: return 32'(v);
        endcase
    endfunction

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] v);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= 32'(v);
        pstrb <= 4'hf;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask

    // Drive a channel 1 sample; compare pin left by the previous one
    task automatic cyc(input logic [12:0] m, input logic v, input logic e);
        sampleMag[0] <= m;
        sampleValid[0] <= v;
        #1 chk(32'(level_alarm_out_ch1), 32'(e));
        @(posedge clock);
    endtask

    // Output picked after the wait: 0 irq, 1 pin of channel 1, 2 pin of channel 2
    task automatic settled(input int sel, input logic e);
        @(negedge clock);
        chk(32'((sel == 0) ? irq : (sel == 1) ? level_alarm_out_ch1 : level_alarm_out_ch2), 32'(e));
        @(posedge clock);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h83c5));
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        for (int c = 0; c < 2; c++) begin
            foreach (offs[k]) rdc(offs[k] + 16'(c * 16'h1000), 32'h0000_0000);
            foreach (offs[k]) begin
                d = 8'($urandom());
                apb(1'b1, offs[k] + 16'(c * 16'h1000), d);
                rdc(offs[k] + 16'(c * 16'h1000), readback(offs[k], d));
            end
            apb(1'b1, 16'h0914 + 16'(c * 16'h1000), 8'h00);
        end
        apb(1'b0, 16'h0915, 8'h00);
        chk(32'(err), 32'h0000_0001);
        apb(1'b0, 16'h1c00, 8'h00);
        chk(32'(err), 32'h0000_0001);
        $display("test registers done");

        apb(1'b1, 16'h0c04, 8'h01);
        steps0 = stepCount[0];
        for (int it = 0; it < 3; it++) begin
            up = (it == 0) ? 13'h0100 : 13'($urandom_range(8190, 1));
            lo = (it == 0) ? 13'h0100 : 13'($urandom_range(up, 1));
            apb(1'b1, 16'h091c, up[7:0]);
            apb(1'b1, 16'h0920, {3'b101, up[12:8]});
            apb(1'b1, 16'h0924, lo[7:0]);
            apb(1'b1, 16'h0928, {3'b110, lo[12:8]});
            apb(1'b1, 16'h092c, 8'h03);
            apb(1'b1, 16'h0930, 8'h00);
            apb(1'b1, 16'h0914, 8'h01);
            cyc(up, 1'b1, 1'b0);
            cyc(up + 13'h0001, 1'b1, 1'b0);
            cyc(lo - 13'h0001, 1'b1, 1'b1);
            cyc(lo - 13'h0001, 1'b1, 1'b1);
            cyc(lo, 1'b1, 1'b1);
            cyc(lo - 13'h0001, 1'b0, 1'b1);
            cyc(lo - 13'h0001, 1'b1, 1'b1);
            cyc(lo - 13'h0001, 1'b1, 1'b1);
            cyc(lo - 13'h0001, 1'b1, 1'b1);
            cyc(13'h0000, 1'b0, 1'b0);
            settled(0, 1'b1);
            rdc(16'h0c00, 32'h0000_0003);
            settled(0, 1'b0);
        end
        chk(32'(stepCount[0]), 32'(steps0 + 8'h03));
        $display("test detection done");

        apb(1'b1, 16'h0c04, 8'h00);
        // Channel 2 upper threshold below full scale so the pin can rise
        apb(1'b1, 16'h1920, 8'h00);
        sampleMag <= {13'h1fff, 13'h1fff};
        sampleValid <= 2'b11;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, i[2] ? 16'h1914 : 16'h0914, {4'h0, i[1], i[0], 2'b01});
            settled(i[2] ? 2 : 1, i[1] ? i[0] : 1'b1);
            if (i[2]) chk(32'(level_alarm_out_ch1), 32'h0000_0001);
        end
        apb(1'b1, 16'h1914, 8'h00);
        settled(2, 1'b0);
        settled(0, 1'b0);
        $display("test override done");
        give_verdict();
    end
endmodule
